// File: src/tm8_pkg.sv
// shared constants and types of the 8-bit timer waveform control block
package tm8_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL_A = 5'h00;
  localparam logic [4:0] OFF_CTRL_B = 5'h04;
  localparam logic [4:0] OFF_COUNT = 5'h08;
  localparam logic [4:0] OFF_CMP_A = 5'h0C;
  localparam logic [4:0] OFF_CMP_B = 5'h10;
  localparam logic [4:0] OFF_FLAGS = 5'h14;
  localparam logic [4:0] OFF_WAVE = 5'h18;

  // control A fields
  localparam int CA_MODE_A_LSB = 6;
  localparam int CA_MODE_B_LSB = 4;
  localparam int CA_WAVE_LOW_LSB = 0;
  localparam logic [7:0] CA_WRITE_MASK = 8'hF3;

  // control B fields
  localparam int CB_RUN_BIT = 0;
  localparam int CB_WAVE_BIT2 = 3;
  localparam logic [7:0] CB_WRITE_MASK = 8'h09;

  // flag and wave status fields
  localparam int FL_OVF_BIT = 0;
  localparam int FL_MATCH_A_BIT = 1;
  localparam int FL_MATCH_B_BIT = 2;
  localparam int WV_A_BIT = 0;
  localparam int WV_B_BIT = 1;
  localparam int WV_UP_BIT = 2;

  // counter limits and reset values
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // wave mode encodings
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;

  typedef enum logic [1:0] {KIND_PLAIN, KIND_FAST, KIND_PHASE} tm8_kind_t;

  typedef struct packed {
    logic [1:0] outMode;
    tm8_kind_t kind;
    logic toggleOk;
    logic cmpIsTop;
  } tm8_chan_cfg_t;

  typedef struct packed {
    logic match;
    logic bottom;
    logic top;
    logic up;
  } tm8_chan_ev_t;

endpackage : tm8_pkg

// File: src/tm8_wave_chan.sv
// one waveform output channel: reacts to matches, BOTTOM and TOP events
`timescale 1ns/100ps
module tm8_wave_chan (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // channel setup and timer events
  input tm8_pkg::tm8_chan_cfg_t cfg,
  input tm8_pkg::tm8_chan_ev_t ev,
  // waveform level
  output logic wave
);

  logic waveReg;
  logic waveNext;

  always_comb begin
    waveNext = waveReg;
    if (cfg.outMode == 2'h1) begin
      // pwm toggle only with mode bit 2; channel b never gets it
      if (ev.match && (cfg.kind == tm8_pkg::KIND_PLAIN || cfg.toggleOk)) begin
        waveNext = ~waveReg;
      end
    end else if (cfg.outMode[1]) begin
      unique case (cfg.kind)
        tm8_pkg::KIND_PLAIN: begin
          if (ev.match) begin
            waveNext = cfg.outMode[0];
          end
        end
        tm8_pkg::KIND_FAST: begin
          if (ev.bottom) begin
            waveNext = ~cfg.outMode[0];
          end else if (ev.match && !cfg.cmpIsTop) begin
            waveNext = cfg.outMode[0];
          end
        end
        tm8_pkg::KIND_PHASE: begin
          if (ev.top && cfg.cmpIsTop) begin
            waveNext = ~cfg.outMode[0];
          end else if (ev.match && !cfg.cmpIsTop) begin
            waveNext = ev.up ? cfg.outMode[0] : ~cfg.outMode[0];
          end
        end
        default: waveNext = waveReg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waveReg <= 1'b0;
    end else begin
      waveReg <= waveNext;
    end
  end

  assign wave = waveReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_plain_act;
    (cfg.kind == tm8_pkg::KIND_PLAIN && cfg.outMode[1] && ev.match) |=> wave == $past(cfg.outMode[0]);
  endproperty
  a_plain_act: assert property (p_plain_act) else $error("plain match action wrong");

  property p_pwm_toggle;
    (cfg.kind != tm8_pkg::KIND_PLAIN && cfg.outMode == 2'h1 && ev.match)
      |=> wave == ($past(wave) ^ $past(cfg.toggleOk));
  endproperty
  a_pwm_toggle: assert property (p_pwm_toggle) else $error("pwm toggle wrong");

  property p_fast_bottom;
    (cfg.kind == tm8_pkg::KIND_FAST && cfg.outMode[1] && ev.bottom) |=> wave != $past(cfg.outMode[0]);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("fast bottom action wrong");

  property p_fast_ignore;
    (cfg.kind == tm8_pkg::KIND_FAST && cfg.outMode[1] && cfg.cmpIsTop && ev.match)
      |=> wave != $past(cfg.outMode[0]);
  endproperty
  a_fast_ignore: assert property (p_fast_ignore) else $error("match at top not ignored");

  property p_pc_match;
    (cfg.kind == tm8_pkg::KIND_PHASE && cfg.outMode[1] && !cfg.cmpIsTop && ev.match)
      |=> wave == ($past(cfg.outMode[0]) ~^ $past(ev.up));
  endproperty
  a_pc_match: assert property (p_pc_match) else $error("phase match action wrong");

  property p_pc_top;
    (cfg.kind == tm8_pkg::KIND_PHASE && cfg.outMode[1] && cfg.cmpIsTop && ev.top)
      |=> wave == !$past(cfg.outMode[0]);
  endproperty
  a_pc_top: assert property (p_pc_top) else $error("phase top action wrong");

endmodule : tm8_wave_chan

// File: src/tm8_timer.sv
// 8-bit timer with waveform mode control, two compare channels, Avalon-MM slave
`timescale 1ns/100ps
// What this block does
// - nonzero channel A output mode hands the A pin to the waveform output.
// - non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - PWM channel A mode 01 toggles on match only when mode bit 2 is set.
// - fast PWM channel A: 10 clears at match, sets at BOTTOM; 11 inverse.
// - fast PWM, compare equals TOP with upper mode bit: ignore match, act at BOTTOM.
// - phase PWM channel A: 10 clears on up match, sets on down; 11 inverse.
// - phase PWM, compare equals TOP with upper mode bit: ignore match, act at TOP.
// - nonzero channel B output mode hands the B pin to the waveform output.
// - non-PWM channel B decodes like channel A.
// - fast PWM channel B: 10 non-inverting, 11 inverting, 01 does nothing.
// - phase PWM channel B: 10 clear up, set down; 11 inverse; 01 nothing.
// - control A bits 3:2 always read zero.
// - low mode bits plus mode bit 2 form the three-bit wave mode.
// - modes 0,3 top 0xFF; mode 2 top compare A; 0,2 immediate, 3 at BOTTOM.
// - modes 1,5 phase PWM updating at TOP; 7 fast with compare A top.
// - MAX is 0xFF, BOTTOM 0x00; modes 0,2,3 flag overflow at MAX.
// - phase PWM reverses at TOP, stepping to TOP-1 on the next timer tick.
// - fast PWM counts up to TOP, then clears to BOTTOM next tick.
module tm8_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // waveform pins
  output logic waveOutA,
  output logic waveOutB,
  output logic pinOverrideA,
  output logic pinOverrideB
);

  logic ackReg, ackNext;
  logic [31:0] rdataReg, rdataNext;
  logic [7:0] ctrlAReg, ctrlANext;
  logic [7:0] ctrlBReg, ctrlBNext;
  logic [7:0] bufAReg, bufANext;
  logic [7:0] bufBReg, bufBNext;
  logic [2:0] flagReg, flagNext;
  logic [7:0] cntReg, cntNext;
  logic [7:0] actAReg, actANext;
  logic [7:0] actBReg, actBNext;
  logic upReg, upNext;
  logic blockReg, blockNext;
  logic busReq, wrEn, cntWr;
  logic [2:0] waveMode;
  logic isPc, isFast, isCtc, cmpTop, tick, immediate;
  logic [7:0] topVal;
  logic atTop, wrapEv, pcTop, pcBottom, matchA, matchB, ovfEv;
  logic waveA, waveB;
  tm8_pkg::tm8_chan_cfg_t cfgA, cfgB;
  tm8_pkg::tm8_chan_ev_t evA, evB;
  tm8_pkg::tm8_kind_t kind;

  // bus handshake: every access takes one wait cycle
  assign busReq = read | write;
  assign waitrequest = busReq & ~ackReg;
  assign wrEn = write & ackReg;
  assign cntWr = wrEn && address == tm8_pkg::OFF_COUNT;

  // mode decode
  assign waveMode = {ctrlBReg[tm8_pkg::CB_WAVE_BIT2], ctrlAReg[tm8_pkg::CA_WAVE_LOW_LSB +: 2]};
  assign isPc = waveMode == tm8_pkg::MODE_PC_MAX || waveMode == tm8_pkg::MODE_PC_CMP;
  assign isFast = waveMode == tm8_pkg::MODE_FAST_MAX || waveMode == tm8_pkg::MODE_FAST_CMP;
  assign isCtc = waveMode == tm8_pkg::MODE_CTC;
  assign cmpTop = isCtc || waveMode == tm8_pkg::MODE_PC_CMP || waveMode == tm8_pkg::MODE_FAST_CMP;
  assign topVal = cmpTop ? actAReg : tm8_pkg::CNT_MAX;
  // reserved modes 4 and 6 behave as immediate-update with a frozen counter
  assign immediate = !isPc && !isFast;
  assign tick = ctrlBReg[tm8_pkg::CB_RUN_BIT];

  // timer events
  assign atTop = tick && cntReg == topVal;
  assign wrapEv = atTop && (isFast || isCtc);
  assign pcTop = atTop && isPc && upReg;
  assign pcBottom = tick && isPc && !upReg && cntReg == tm8_pkg::CNT_BOTTOM;
  // a counter write suppresses the next tick's match
  assign matchA = tick && !blockReg && cntReg == actAReg;
  assign matchB = tick && !blockReg && cntReg == actBReg;

  always_comb begin
    unique case (waveMode)
      tm8_pkg::MODE_NORMAL, tm8_pkg::MODE_CTC, tm8_pkg::MODE_FAST_MAX: begin
        ovfEv = tick && cntReg == tm8_pkg::CNT_MAX;
      end
      tm8_pkg::MODE_PC_MAX, tm8_pkg::MODE_PC_CMP: ovfEv = pcBottom;
      tm8_pkg::MODE_FAST_CMP: ovfEv = atTop;
      default: ovfEv = 1'b0;
    endcase
  end

  // bus answer
  always_comb begin
    ackNext = busReq & ~ackReg;
    rdataNext = rdataReg;
    if (read && !ackReg) begin
      rdataNext = 32'h0000_0000;
      case (address)
        tm8_pkg::OFF_CTRL_A: rdataNext[7:0] = ctrlAReg & tm8_pkg::CA_WRITE_MASK;
        tm8_pkg::OFF_CTRL_B: rdataNext[7:0] = ctrlBReg;
        tm8_pkg::OFF_COUNT: rdataNext[7:0] = cntReg;
        tm8_pkg::OFF_CMP_A: rdataNext[7:0] = bufAReg;
        tm8_pkg::OFF_CMP_B: rdataNext[7:0] = bufBReg;
        tm8_pkg::OFF_FLAGS: rdataNext[2:0] = flagReg;
        tm8_pkg::OFF_WAVE: begin
          rdataNext[tm8_pkg::WV_A_BIT] = waveA;
          rdataNext[tm8_pkg::WV_B_BIT] = waveB;
          rdataNext[tm8_pkg::WV_UP_BIT] = upReg;
        end
        default: rdataNext = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ackReg <= 1'b0;
      rdataReg <= 32'h0000_0000;
    end else begin
      ackReg <= ackNext;
      rdataReg <= rdataNext;
    end
  end

  // software registers; flags are write-one-to-clear, a same-cycle set wins
  always_comb begin
    ctrlANext = ctrlAReg;
    ctrlBNext = ctrlBReg;
    bufANext = bufAReg;
    bufBNext = bufBReg;
    flagNext = flagReg;
    if (wrEn) begin
      case (address)
        tm8_pkg::OFF_CTRL_A: ctrlANext = writedata[7:0] & tm8_pkg::CA_WRITE_MASK;
        tm8_pkg::OFF_CTRL_B: ctrlBNext = writedata[7:0] & tm8_pkg::CB_WRITE_MASK;
        tm8_pkg::OFF_CMP_A: bufANext = writedata[7:0];
        tm8_pkg::OFF_CMP_B: bufBNext = writedata[7:0];
        tm8_pkg::OFF_FLAGS: flagNext = flagReg & ~writedata[2:0];
        default: flagNext = flagReg;
      endcase
    end
    flagNext[tm8_pkg::FL_OVF_BIT] = flagNext[tm8_pkg::FL_OVF_BIT] | ovfEv;
    flagNext[tm8_pkg::FL_MATCH_A_BIT] = flagNext[tm8_pkg::FL_MATCH_A_BIT] | matchA;
    flagNext[tm8_pkg::FL_MATCH_B_BIT] = flagNext[tm8_pkg::FL_MATCH_B_BIT] | matchB;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlAReg <= tm8_pkg::RST_CTRL;
      ctrlBReg <= tm8_pkg::RST_CTRL;
      bufAReg <= tm8_pkg::RST_CMP;
      bufBReg <= tm8_pkg::RST_CMP;
      flagReg <= tm8_pkg::RST_FLAGS;
    end else begin
      ctrlAReg <= ctrlANext;
      ctrlBReg <= ctrlBNext;
      bufAReg <= bufANext;
      bufBReg <= bufBNext;
      flagReg <= flagNext;
    end
  end

  // counter, direction and double-buffered compare values
  always_comb begin
    cntNext = cntReg;
    upNext = isPc ? upReg : 1'b1;
    blockNext = tick ? 1'b0 : blockReg;
    if (cntWr) begin
      cntNext = writedata[7:0];
      blockNext = 1'b1;
    end else if (tick) begin
      if (isPc) begin
        if (upReg) begin
          if (cntReg == topVal) begin
            upNext = 1'b0;
            cntNext = (cntReg == tm8_pkg::CNT_BOTTOM) ? cntReg : cntReg - 8'h01;
          end else begin
            cntNext = cntReg + 8'h01;
          end
        end else if (cntReg == tm8_pkg::CNT_BOTTOM) begin
          upNext = 1'b1;
          cntNext = cntReg + 8'h01;
        end else begin
          cntNext = cntReg - 8'h01;
        end
      end else if (isFast || isCtc) begin
        cntNext = atTop ? tm8_pkg::CNT_BOTTOM : cntReg + 8'h01;
      end else if (waveMode == tm8_pkg::MODE_NORMAL) begin
        cntNext = cntReg + 8'h01;
      end
    end
    // pwm updates at the period boundary keep each period glitch-free
    if (immediate || (isPc && pcTop) || (isFast && wrapEv)) begin
      actANext = bufAReg;
      actBNext = bufBReg;
    end else begin
      actANext = actAReg;
      actBNext = actBReg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cntReg <= tm8_pkg::RST_COUNT;
      upReg <= 1'b1;
      blockReg <= 1'b0;
      actAReg <= tm8_pkg::RST_CMP;
      actBReg <= tm8_pkg::RST_CMP;
    end else begin
      cntReg <= cntNext;
      upReg <= upNext;
      blockReg <= blockNext;
      actAReg <= actANext;
      actBReg <= actBNext;
    end
  end

  // channel setup
  assign kind = isPc ? tm8_pkg::KIND_PHASE : (isFast ? tm8_pkg::KIND_FAST : tm8_pkg::KIND_PLAIN);
  assign cfgA = '{outMode: ctrlAReg[tm8_pkg::CA_MODE_A_LSB +: 2], kind: kind,
                  toggleOk: ctrlBReg[tm8_pkg::CB_WAVE_BIT2], cmpIsTop: actAReg == topVal};
  assign cfgB = '{outMode: ctrlAReg[tm8_pkg::CA_MODE_B_LSB +: 2], kind: kind,
                  toggleOk: 1'b0, cmpIsTop: actBReg == topVal};
  assign evA = '{match: matchA, bottom: wrapEv, top: pcTop, up: upReg};
  assign evB = '{match: matchB, bottom: wrapEv, top: pcTop, up: upReg};

  tm8_wave_chan u_chanA (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfgA),
    .ev(evA),
    .wave(waveA)
  );

  tm8_wave_chan u_chanB (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfgB),
    .ev(evB),
    .wave(waveB)
  );

  // pin data direction stays with the port logic outside
  assign pinOverrideA = |ctrlAReg[tm8_pkg::CA_MODE_A_LSB +: 2];
  assign pinOverrideB = |ctrlAReg[tm8_pkg::CA_MODE_B_LSB +: 2];
  assign waveOutA = waveA;
  assign waveOutB = waveB;
  assign readdata = rdataReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_resv_read;
    (read && ackReg && address == tm8_pkg::OFF_CTRL_A) |-> readdata[3:2] == 2'h0;
  endproperty
  a_resv_read: assert property (p_resv_read) else $error("reserved bits read nonzero");

  property p_override;
    (wrEn && address == tm8_pkg::OFF_CTRL_A && writedata[7:6] != 2'h0) |=> pinOverrideA;
  endproperty
  a_override: assert property (p_override) else $error("pin A not taken over");

  property p_normal_wrap;
    (waveMode == tm8_pkg::MODE_NORMAL && tick && cntReg == tm8_pkg::CNT_MAX && !cntWr)
      |=> cntReg == tm8_pkg::CNT_BOTTOM && flagReg[tm8_pkg::FL_OVF_BIT];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap or overflow wrong");

  property p_ctc_top;
    (isCtc && tick && cntReg == actAReg && !cntWr) |=> cntReg == tm8_pkg::CNT_BOTTOM;
  endproperty
  a_ctc_top: assert property (p_ctc_top) else $error("ctc did not clear at compare A");

  property p_fast_wrap;
    (isFast && atTop && !cntWr) |=> cntReg == tm8_pkg::CNT_BOTTOM;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast pwm did not clear after TOP");

  sequence s_pc_at_top;
    isPc && tick && upReg && cntReg == topVal && topVal != tm8_pkg::CNT_BOTTOM && !cntWr;
  endsequence
  sequence s_pc_turned;
    !upReg && cntReg == $past(cntReg) - 8'h01;
  endsequence
  property p_pc_turn;
    s_pc_at_top |=> s_pc_turned;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase pwm did not turn at TOP");

  property p_pc_ovf;
    (isPc && tick && !upReg && cntReg == tm8_pkg::CNT_BOTTOM) |=> flagReg[tm8_pkg::FL_OVF_BIT];
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("phase pwm overflow missing");

  property p_match_tick;
    $rose(flagReg[tm8_pkg::FL_MATCH_A_BIT]) |-> $past(tick) && $past(cntReg) == $past(actAReg);
  endproperty
  a_match_tick: assert property (p_match_tick) else $error("match flag without tick");

endmodule : tm8_timer

// File: testbench/tb_top.sv
// self-checking bench for the 8-bit timer waveform control block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  typedef struct {string nm; logic [31:0] v;} tm8_exp_t;
  typedef struct {logic [7:0] ca, cb, cmpA, cmpB; int win, expA, expB;} tm8_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic waveOutA;
  logic waveOutB;
  logic pinOverrideA;
  logic pinOverrideB;
  int error_cnt = 0;
  int compares = 0;
  int seed = 40276;
  tm8_exp_t expQ[$];
  tm8_row_t rows[9];

  tm8_timer i_tm8_timer (
    .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .waveOutA(waveOutA), .waveOutB(waveOutB),
    .pinOverrideA(pinOverrideA), .pinOverrideB(pinOverrideB)
  );

  always #5 clk = ~clk;

  // waitrequest is sampled on the rising edge; the request stands until it is seen low there
  task automatic bus_wait;
    do @(posedge clk); while (waitrequest !== 1'b0);
  endtask : bus_wait

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    address <= a;
    writedata <= {24'h0, d};
    write <= 1'b1;
    bus_wait();
    write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e, input string nm);
    tm8_exp_t x;
    x.nm = nm;
    x.v = {24'h0, e};
    expQ.push_back(x);
    address <= a;
    read <= 1'b1;
    bus_wait();
    read <= 1'b0;
    @(posedge clk);
  endtask : rd

  // read data is taken at the very edge where waitrequest is seen low
  always @(posedge clk) begin
    tm8_exp_t x;
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (expQ.size() == 0) begin
        x.nm = "unexpected read";
        x.v = 32'hFFFFFFFF;
      end else begin
        x = expQ.pop_front();
      end
      `CHK(x.nm, x.v, readdata)
    end
  end

  task automatic measure(input int n, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge clk);
      ha += int'(waveOutA === 1'b1);
      hb += int'(waveOutB === 1'b1);
    end
    @(posedge clk);
  endtask : measure

  // one match per channel: count starts below both compares and runs well short of a wrap
  task automatic one_match(input logic [1:0] m, input logic ea, input logic eb);
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    wr(tm8_pkg::OFF_COUNT, 8'h30);
    wr(tm8_pkg::OFF_CTRL_A, {m, m, 4'h0});
    wr(tm8_pkg::OFF_CTRL_B, 8'h01);
    repeat (40) @(posedge clk);
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    `CHK("waveA", ea, waveOutA)
    `CHK("waveB", eb, waveOutB)
    rd(tm8_pkg::OFF_WAVE, {5'h00, 1'b1, eb, ea}, "status");
  endtask : one_match

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #800000;
    error_cnt++;
    $display("BAD watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    logic [7:0] r;
    int ha;
    int hb;
    rows[0] = '{8'hA3, 8'h01, 8'h80, 8'h40, 256, 8'h81, 8'h41};
    rows[1] = '{8'hF3, 8'h01, 8'h80, 8'h40, 256, 8'h7F, 8'hBF};
    rows[2] = '{8'hB3, 8'h01, 8'hFF, 8'h40, 256, 256, 8'hBF};
    rows[3] = '{8'h53, 8'h01, 8'h80, 8'h40, 256, -1, -1};
    rows[4] = '{8'h63, 8'h09, 8'h7F, 8'h20, 256, 128, 8'h42};
    rows[5] = '{8'hA3, 8'h09, 8'h7F, 8'h20, 256, 256, 8'h42};
    rows[6] = '{8'hB1, 8'h01, 8'h40, 8'h40, 510, 8'h80, 510 - 8'h80};
    rows[7] = '{8'hA1, 8'h09, 8'h7F, 8'h20, 254, 254, 8'h40};
    rows[8] = '{8'hD1, 8'h09, 8'h7F, 8'h20, 254, 0, -1};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      // status shows the count direction, which is up after reset
      rd(5'(a * 4), (a == 6) ? 8'h04 : 8'h00, "reset value");
    end
    wr(5'h1C, 8'h5A);
    rd(5'h1C, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      wr(tm8_pkg::OFF_CTRL_A, r);
      rd(tm8_pkg::OFF_CTRL_A, r & tm8_pkg::CA_WRITE_MASK, "ctrlA");
      `CHK("overrideA", logic'(r[7:6] != 2'b00), pinOverrideA)
      `CHK("overrideB", logic'(r[5:4] != 2'b00), pinOverrideB)
    end
    wr(tm8_pkg::OFF_CTRL_A, 8'h00);
    wr(tm8_pkg::OFF_CTRL_B, 8'hFE);
    rd(tm8_pkg::OFF_CTRL_B, 8'h08, "ctrlB");
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    wr(tm8_pkg::OFF_CMP_A, 8'h40);
    wr(tm8_pkg::OFF_CMP_B, 8'h44);
    one_match(2'b11, 1'b1, 1'b1);
    one_match(2'b10, 1'b0, 1'b0);
    one_match(2'b01, 1'b1, 1'b1);
    one_match(2'b01, 1'b0, 1'b0);
    wr(tm8_pkg::OFF_CTRL_A, 8'h00);
    wr(tm8_pkg::OFF_FLAGS, 8'h07);
    wr(tm8_pkg::OFF_COUNT, 8'hF0);
    wr(tm8_pkg::OFF_CTRL_B, 8'h01);
    repeat (40) @(posedge clk);
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    rd(tm8_pkg::OFF_FLAGS, 8'h01, "flags normal");
    wr(tm8_pkg::OFF_FLAGS, 8'h07);
    rd(tm8_pkg::OFF_FLAGS, 8'h00, "flags cleared");
    wr(tm8_pkg::OFF_CMP_A, 8'h10);
    wr(tm8_pkg::OFF_CMP_B, 8'h08);
    wr(tm8_pkg::OFF_COUNT, 8'h00);
    wr(tm8_pkg::OFF_CTRL_A, 8'h02);
    wr(tm8_pkg::OFF_CTRL_B, 8'h01);
    repeat (300) @(posedge clk);
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    rd(tm8_pkg::OFF_FLAGS, 8'h06, "flags clear on match");
    wr(tm8_pkg::OFF_FLAGS, 8'h07);
    // compares are loaded in normal mode so the active copies update at once
    foreach (rows[k]) begin
      wr(tm8_pkg::OFF_CTRL_B, 8'h00);
      wr(tm8_pkg::OFF_CTRL_A, 8'h00);
      wr(tm8_pkg::OFF_CMP_A, rows[k].cmpA);
      wr(tm8_pkg::OFF_CMP_B, rows[k].cmpB);
      wr(tm8_pkg::OFF_COUNT, 8'h00);
      wr(tm8_pkg::OFF_CTRL_A, rows[k].ca);
      wr(tm8_pkg::OFF_CTRL_B, rows[k].cb);
      repeat (1100) @(posedge clk);
      measure(rows[k].win, ha, hb);
      if (rows[k].expA < 0) `CHK("constA", 1, int'(ha == 0 || ha == rows[k].win))
      else `CHK("dutyA", rows[k].expA, ha)
      if (rows[k].expB < 0) `CHK("constB", 1, int'(hb == 0 || hb == rows[k].win))
      else `CHK("dutyB", rows[k].expB, hb)
    end
    wr(tm8_pkg::OFF_CTRL_B, 8'h00);
    repeat (4) @(posedge clk);
    `CHK("queue drained", 0, expQ.size())
    close_out();
  end
endmodule : tb_top
